// File: rtl/asm_pkg.sv
// Purpose: Shared constants and types of the address-mode serial slave.
// Assumes: Serial pins are already synchronous to ref_clk.
// Notes: Counts are numbers of rising serial clock edges seen in a frame.
package asm_pkg;
  localparam logic [7:0] ALIGN_PATTERN = 8'h25;
  localparam logic [15:0] CLEAR_CMD = 16'h6ca9;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_SEED = 8'h00;
  localparam logic [7:0] BYTE_IDLE = 8'hff;
  localparam logic [4:0] CNT_ZERO = 5'h00;
  localparam logic [4:0] CNT_ONE = 5'h01;
  localparam logic [4:0] CNT_ADDR = 5'h07;
  localparam logic [4:0] CNT_ADDR_CHK = 5'h08;
  localparam logic [4:0] CNT_PAYLOAD = 5'h0f;
  localparam logic [4:0] CNT_CRC = 5'h17;
  localparam logic [4:0] CNT_BYTE2 = 5'h08;
  localparam logic [4:0] CNT_BYTE3 = 5'h10;
  localparam logic [4:0] CNT_MAX = 5'h1f;
  localparam logic [4:0] FRAME_PLAIN = 5'h10;
  localparam logic [4:0] FRAME_CRC = 5'h18;

  typedef struct packed {
    logic crc_en;
    logic addr_chk_en;
    logic cnt_chk_en;
  } asm_cfg_t;

  typedef struct packed {
    logic crc_err;
    logic addr_err;
    logic cnt_err;
  } asm_err_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic sdi;
  } asm_pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD = 2'b01,
    ST_DATA = 2'b11,
    ST_CRC = 2'b10
  } asm_state_t;
endpackage : asm_pkg

// File: rtl/asm_crc8.sv
// Purpose: Serial CRC-8 accumulator, one bit per step, MSB first.
// Assumes: clear and step are never both set.
// Notes: Polynomial and seed come from the package.
`timescale 1ns/100ps
module asm_crc8
  import asm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic step,
  input wire logic bit_in,
  output logic [7:0] crc
);
  logic [7:0] next_crc;
  wire feedback = crc[7] ^ bit_in;

  assign next_crc = {crc[6:0], 1'b0} ^ (feedback ? CRC_POLY : 8'h00);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || clear) begin
      crc <= CRC_SEED;
    end else if (step) begin
      crc <= next_crc;
    end
  end
endmodule : asm_crc8

// File: rtl/asm_slave.sv
// Purpose: Address-mode serial slave front end with error flags.
// Assumes: Pins sampled on ref_clk, serial clock well below ref_clk / 4.
// Notes: Register map lives outside; it answers reg_rdata and address checks.
// How it works
// - Either idle clock level is accepted, a leading falling edge is ignored.
// - The block is always in address mode, one command per chip-select frame.
// - With CRC enabled a frame carries 24 bits instead of 16.
// - Clock-count, bad-address and CRC errors set sticky flags the host can read.
// - Input is sampled on rising clock edges and output shifts on falling ones.
// - The output only pulls low or floats, never drives high.
// - A frame runs from chip-select fall to rise and should hold 16 clocks, or 24 with CRC enabled.
// - The first input bit chooses write when 0 and read when 1.
// - Seven address bits follow the direction bit, then eight data bits.
// - In a read the trailing eight input bits are ignored, except that with CRC enabled they feed the input CRC check.
// - The address is latched at the eighth rising edge.
// - A read shifts out the addressed byte on falling edges nine to sixteen.
// - Without CRC a write lands at the sixteenth rising edge.
// - The first eight falling edges always carry the alignment byte.
// - With CRC the write lands at the 24th edge and only if the CRC matches.
// - A frame with fewer than 16 clocks never writes.
`timescale 1ns/100ps
module asm_slave
  import asm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire asm_pins_t pins,
  output logic sdo_o,
  output logic sdo_oe_n,
  input wire asm_cfg_t cfg,
  input wire logic addr_rd_ok,
  input wire logic addr_wr_ok,
  input wire logic [7:0] reg_rdata,
  output logic [6:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  output asm_err_t err_flags
);
  asm_state_t state;
  asm_state_t next_state;
  logic cs_q;
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [15:0] payload;
  logic [7:0] out_shift;
  logic is_read;
  logic addr_bad;
  logic drive_low;
  logic [7:0] rx_crc;
  logic [7:0] tx_crc;
  asm_err_t next_flags;

  // Edge detection on synchronous pins; edges only count inside a frame
  wire active = !pins.cs_n;
  wire cs_fall = active && cs_q;
  wire cs_rise = pins.cs_n && !cs_q;
  wire sclk_rise = active && !cs_fall && pins.sclk && !sclk_q;
  // Mode 3 opens with a falling edge before any rising one; skip it
  wire sclk_fall = active && !pins.sclk && sclk_q && (bit_cnt != CNT_ZERO);
  wire [7:0] in_byte = {shift_in[6:0], pins.sdi};
  wire [15:0] in_word = {shift_in[14:0], pins.sdi};
  wire [4:0] frame_len = cfg.crc_en ? FRAME_CRC : FRAME_PLAIN;
  wire at_addr = sclk_rise && (bit_cnt == CNT_ADDR);
  wire at_chk = sclk_rise && (bit_cnt == CNT_ADDR_CHK);
  wire at_payload = sclk_rise && (bit_cnt == CNT_PAYLOAD);
  wire at_crc = sclk_rise && (bit_cnt == CNT_CRC);
  wire is_clear = (in_word == CLEAR_CMD);
  wire is_clear_p = (payload == CLEAR_CMD);
  wire addr_ok = is_read ? addr_rd_ok : addr_wr_ok;
  // Clear command address is exempt from the address check
  // Payload is not captured yet at the ninth edge; the first byte sits in shift_in
  wire addr_bad_now = !addr_ok && cfg.addr_chk_en && (shift_in[7:0] != CLEAR_CMD[15:8]);
  wire crc_match = (in_byte == rx_crc);
  // Write commit points; a short frame never reaches them
  wire commit_plain = at_payload && !cfg.crc_en && !is_read && !addr_bad;
  wire commit_crc = at_crc && cfg.crc_en && !is_read && !addr_bad && crc_match;
  wire commit_plain_wr = commit_plain && !is_clear;
  wire commit_crc_wr = commit_crc && !is_clear_p;
  wire do_clear = (commit_plain && is_clear) || (commit_crc && is_clear_p);
  wire set_cnt = cs_rise && cfg.cnt_chk_en && (bit_cnt != frame_len);
  wire set_addr = at_chk && addr_bad_now;
  wire set_crc = at_crc && cfg.crc_en && !crc_match;
  wire step_rx = sclk_rise && (bit_cnt <= CNT_PAYLOAD);
  wire step_tx = sclk_rise && (bit_cnt <= CNT_PAYLOAD);
  wire load_data = sclk_fall && (bit_cnt == CNT_BYTE2);
  wire load_crc = sclk_fall && (bit_cnt == CNT_BYTE3);
  // Write frames float the data byte; the read byte replaces it
  wire [7:0] data_byte = is_read ? reg_rdata : BYTE_IDLE;
  wire [7:0] crc_byte = cfg.crc_en ? tx_crc : BYTE_IDLE;

  // Set wins over clear in the same cycle
  assign next_flags.cnt_err = (err_flags.cnt_err && !do_clear) || set_cnt;
  assign next_flags.addr_err = (err_flags.addr_err && !do_clear) || set_addr;
  assign next_flags.crc_err = (err_flags.crc_err && !do_clear) || set_crc;
  assign sdo_o = 1'b0;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (cs_fall) next_state = ST_CMD;
      ST_CMD: if (at_addr) next_state = ST_DATA;
      ST_DATA: if (at_payload && cfg.crc_en) next_state = ST_CRC;
      ST_CRC: next_state = ST_CRC;
    endcase
    if (pins.cs_n) begin
      next_state = ST_IDLE;
    end
  end

  asm_crc8 u_rx_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(cs_fall),
    .step(step_rx),
    .bit_in(pins.sdi),
    .crc(rx_crc)
  );

  asm_crc8 u_tx_crc (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(cs_fall),
    .step(step_tx),
    .bit_in(out_shift[7]),
    .crc(tx_crc)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
      err_flags <= '0;
    end else begin
      state <= next_state;
      cs_q <= pins.cs_n;
      sclk_q <= pins.sclk;
      err_flags <= next_flags;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || cs_fall) begin
      bit_cnt <= CNT_ZERO;
      shift_in <= '0;
    end else if (sclk_rise) begin
      shift_in <= in_word;
      if (bit_cnt != CNT_MAX) begin
        bit_cnt <= bit_cnt + CNT_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_addr <= '0;
      is_read <= 1'b0;
      reg_rd <= 1'b0;
    end else begin
      reg_rd <= at_addr && shift_in[6];
      if (at_addr) begin
        reg_addr <= in_byte[6:0];
        is_read <= shift_in[6];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n || cs_fall) begin
      addr_bad <= 1'b0;
      payload <= '0;
    end else begin
      if (set_addr) begin
        addr_bad <= 1'b1;
      end
      if (at_payload) begin
        payload <= in_word;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_wr <= 1'b0;
      reg_wdata <= '0;
    end else begin
      reg_wr <= commit_plain_wr || commit_crc_wr;
      if (commit_plain_wr) begin
        reg_wdata <= in_byte;
      end else if (commit_crc_wr) begin
        reg_wdata <= payload[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      out_shift <= BYTE_IDLE;
    end else if (cs_fall) begin
      out_shift <= ALIGN_PATTERN;
    end else if (load_data) begin
      out_shift <= data_byte;
    end else if (load_crc) begin
      out_shift <= crc_byte;
    end else if (sclk_fall) begin
      out_shift <= {out_shift[6:0], 1'b1};
    end
  end

  // Open drain: enable low only while pulling the line low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive_low <= 1'b0;
    end else begin
      drive_low <= active && !cs_fall && !out_shift[7];
    end
  end
  assign sdo_oe_n = !drive_low;

  default clocking dclk @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  AST_FLOAT_IDLE: assert property (pins.cs_n |=> sdo_oe_n)
    else $error("data output not floating outside a frame");
  AST_ALIGN_BITS: assert property (sclk_rise && bit_cnt < CNT_BYTE2 |->
    out_shift[7] == ALIGN_PATTERN[3'h7 - bit_cnt[2:0]])
    else $error("alignment bit wrong before rising edge");
  AST_ADDR_LATCH: assert property (at_addr |=> reg_addr == $past(in_byte[6:0]))
    else $error("address not latched at eighth rising edge");
  AST_WRITE_EDGE: assert property (reg_wr |-> bit_cnt == frame_len)
    else $error("write not at the final rising edge");
  AST_NO_SHORT: assert property (active && bit_cnt < FRAME_PLAIN |-> !reg_wr)
    else $error("write inside a short frame");
  AST_NO_READ_WR: assert property (reg_wr |-> !is_read)
    else $error("write during a read command");
  AST_READ_BYTE: assert property (load_data && is_read |=> out_shift == $past(reg_rdata))
    else $error("read byte not loaded at ninth falling edge");
  AST_SAMPLE: assert property (sclk_rise |=> shift_in[0] == $past(pins.sdi))
    else $error("input not sampled on rising edge");
  AST_CRC_BAD: assert property (set_crc |=> !reg_wr ##0 err_flags.crc_err)
    else $error("bad CRC did not block the write");
  AST_CNT_FLAG: assert property (set_cnt |=> err_flags.cnt_err [*2])
    else $error("clock count error not flagged");
  AST_CRC_LEN: assert property (cfg.crc_en && at_payload |=> !reg_wr)
    else $error("write at 16th edge with CRC on");

  // Frame sequencing
  AST_IDLE_STATE: assert property (pins.cs_n |=> state == ST_IDLE)
    else $error("state not idle with chip select high");
  AST_CMD_STATE: assert property (cs_fall |=> state == ST_CMD)
    else $error("frame start did not enter command phase");
  AST_DATA_STATE: assert property (at_addr |=> state == ST_DATA)
    else $error("address edge did not enter data phase");
  AST_CRC_STATE: assert property (at_payload && cfg.crc_en |=> state == ST_CRC)
    else $error("sixteenth edge did not enter CRC phase");
  AST_CNT_RESTART: assert property (cs_fall |=> bit_cnt == CNT_ZERO)
    else $error("edge count not restarted at frame start");
  AST_RX_HOLD: assert property (state == ST_CRC && sclk_rise |=> $stable(rx_crc))
    else $error("input CRC moved during CRC byte");

  // Output path
  AST_ALIGN_LOAD: assert property (cs_fall |=> out_shift == ALIGN_PATTERN)
    else $error("alignment byte not loaded at frame start");
  AST_PIN_LEVEL: assert property (sclk_rise |-> sdo_oe_n == out_shift[7])
    else $error("output line does not match the bit in flight");
  AST_FALL_SHIFT: assert property (sclk_fall && !cs_fall && !load_data && !load_crc |=>
    out_shift == {$past(out_shift[6:0]), 1'b1})
    else $error("output not shifted on falling edge");
  AST_LEAD_FALL: assert property (active && !cs_fall && !pins.sclk && sclk_q &&
    bit_cnt == CNT_ZERO |=> $stable(out_shift))
    else $error("leading falling edge shifted the output");
  AST_WR_FLOAT: assert property (load_data && !is_read |=> out_shift == BYTE_IDLE)
    else $error("write frame does not float the data byte");
  AST_CRC_BYTE: assert property (load_crc && cfg.crc_en |=>
    out_shift == $past(tx_crc))
    else $error("output CRC byte not loaded");
  AST_CRC_SEED: assert property (cs_fall |=> rx_crc == CRC_SEED && tx_crc == CRC_SEED)
    else $error("CRC not seeded at frame start");

  // Register side
  AST_RD_POINT: assert property (reg_rd |-> is_read && bit_cnt == CNT_ADDR_CHK)
    else $error("read strobe outside a read at the eighth edge");
  AST_RD_PULSE: assert property (reg_rd |=> !reg_rd)
    else $error("read strobe longer than one cycle");
  AST_WR_PULSE: assert property (reg_wr |=> !reg_wr)
    else $error("write strobe longer than one cycle");
  AST_WR_DATA: assert property (commit_plain_wr |=> reg_wdata == $past(in_byte))
    else $error("write data not the last input byte");
  AST_PAYLOAD: assert property (at_payload |=> payload == $past(in_word))
    else $error("payload not captured at sixteenth edge");
  AST_PLAIN_WR: assert property (reg_wr && !cfg.crc_en |-> $past(at_payload))
    else $error("plain write not after sixteenth edge");
  AST_CRC_WR: assert property (reg_wr && cfg.crc_en |->
    $past(at_crc) && $past(crc_match))
    else $error("CRC write without matching CRC at last edge");

  // Error flags
  AST_ADDR_FLAG: assert property (set_addr |=> err_flags.addr_err)
    else $error("bad address not flagged");
  AST_ADDR_BLOCK: assert property (addr_bad && (at_payload || at_crc) |=> !reg_wr)
    else $error("write to a bad address");
  AST_CLEAR: assert property (do_clear |=> err_flags == '0)
    else $error("clear command left flags set");
  AST_CNT_KEEP: assert property (cs_rise && bit_cnt == frame_len |=>
    err_flags.cnt_err == $past(err_flags.cnt_err))
    else $error("count flag changed on a full frame");
endmodule : asm_slave

// File: sim/asm_host.sv
// Purpose: Host model driving the serial pins of the slave.
// Assumes: Pull-up on the data line; pins change at ref_clk falling edges.
// Notes: Each serial clock level lasts four ref_clk cycles.
`timescale 1ns/100ps
module asm_host
  import asm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic sdo_o,
  input wire logic sdo_oe_n,
  output asm_pins_t pins
);
  logic line;
  assign line = sdo_oe_n ? 1'b1 : sdo_o;
  initial pins = '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};

  task automatic xfer(input logic [23:0] tx, input int nbits, input logic idle,
                      output logic [23:0] rx);
    rx = '0;
    @(negedge ref_clk);
    pins.sclk = idle;
    repeat (2) @(negedge ref_clk);
    pins.cs_n = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      pins.sclk = 1'b0;
      pins.sdi = tx[i];
      repeat (4) @(negedge ref_clk);
      pins.sclk = 1'b1;
      rx = {rx[22:0], line};
      repeat (4) @(negedge ref_clk);
    end
    pins.sclk = idle;
    repeat (4) @(negedge ref_clk);
    pins.cs_n = 1'b1;
    // Released line must not keep its last value
    pins.sdi = ~pins.sdi;
    repeat (4) @(negedge ref_clk);
  endtask : xfer
endmodule : asm_host

// File: sim/asm_slave_tb_top.sv
// Purpose: Self-checking bench of the address-mode serial slave.
// Assumes: Register map modelled here, readable below 0x20, writable below 0x10.
// Notes: Map returns the address xor 0x3c.
`timescale 1ns/100ps
module asm_slave_tb_top import asm_pkg::*;;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  asm_pins_t pins;
  asm_cfg_t cfg = '{crc_en: 1'b0, addr_chk_en: 1'b1, cnt_chk_en: 1'b1};
  logic sdo_o, sdo_oe_n, reg_wr, reg_rd, addr_rd_ok, addr_wr_ok;
  logic [6:0] reg_addr, wr_addr;
  logic [7:0] reg_wdata, wr_data, reg_rdata;
  logic [23:0] rx;
  asm_err_t err_flags;
  int err_count = 0;
  int n_checks = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;

  always #2 ref_clk = ~ref_clk;
  assign addr_rd_ok = reg_addr < 7'h20;
  assign addr_wr_ok = reg_addr < 7'h10;
  assign reg_rdata = {1'b0, reg_addr} ^ 8'h3c;

  asm_slave asm_slave_inst (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
    .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n), .cfg(cfg), .addr_rd_ok(addr_rd_ok),
    .addr_wr_ok(addr_wr_ok), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .err_flags(err_flags));
  asm_host asm_host_inst (.ref_clk(ref_clk), .sdo_o(sdo_o), .sdo_oe_n(sdo_oe_n),
    .pins(pins));

  always @(posedge ref_clk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
    if (reg_rd === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
  end

  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc8

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic fr(input logic [23:0] tx, input int n, input logic idle);
    asm_host_inst.xfer(tx, n, idle, rx);
  endtask : fr

  task automatic t_write();
    fr(24'h000ca5, 16, 1'b0);
    chk("align", 24'h25, rx[15:8]);
    chk("float", 24'hff, rx[7:0]);
    chk("wr_cnt", 24'd1, wr_cnt);
    chk("wr_addr", 24'h0c, wr_addr);
    chk("wr_data", 24'ha5, wr_data);
  endtask : t_write

  task automatic t_read();
    fr(24'h0085c3, 16, 1'b1);
    chk("align", 24'h25, rx[15:8]);
    chk("rdata", 24'h39, rx[7:0]);
    chk("reg_addr", 24'h05, reg_addr);
    chk("rd_cnt", 24'd1, rd_cnt);
    chk("wr_cnt", 24'd1, wr_cnt);
  endtask : t_read

  task automatic t_errors();
    fr(24'h000031, 12, 1'b0);
    chk("wr_cnt", 24'd1, wr_cnt);
    chk("err", 24'h1, err_flags);
    fr(24'h001500, 16, 1'b1);
    chk("wr_cnt", 24'd1, wr_cnt);
    chk("err", 24'h3, err_flags);
    fr(24'h006ca9, 16, 1'b0);
    chk("err", 24'h0, err_flags);
  endtask : t_errors

  task automatic t_crc();
    cfg.crc_en = 1'b1;
    fr({16'h0733, crc8(16'h0733)}, 24, 1'b0);
    chk("wr_cnt", 24'd2, wr_cnt);
    chk("wr_data", 24'h33, wr_data);
    fr({16'h0744, ~crc8(16'h0744)}, 24, 1'b1);
    chk("wr_cnt", 24'd2, wr_cnt);
    chk("err", 24'h4, err_flags);
    fr({16'h8500, crc8(16'h8500)}, 24, 1'b0);
    chk("rd_crc", crc8(16'h2539), rx[7:0]);
    cfg.crc_en = 1'b0;
  endtask : t_crc

  task automatic t_checks_off();
    cfg.addr_chk_en = 1'b0;
    cfg.cnt_chk_en = 1'b0;
    fr(24'h0015c3, 16, 1'b1);
    chk("wr_cnt", 24'd3, wr_cnt);
    chk("wr_addr", 24'h15, wr_addr);
    chk("wr_data", 24'hc3, wr_data);
    fr(24'h000031, 12, 1'b0);
    chk("wr_cnt", 24'd3, wr_cnt);
    chk("err", 24'h4, err_flags);
    cfg.addr_chk_en = 1'b1;
    cfg.cnt_chk_en = 1'b1;
  endtask : t_checks_off

  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    t_write();
    t_read();
    t_errors();
    t_crc();
    t_checks_off();
    report_and_stop();
  end

  initial begin
    // Ten frames need about 1600 cycles
    repeat (6000) @(posedge ref_clk);
    err_count++;
    report_and_stop();
  end
endmodule : asm_slave_tb_top
